// ===== eep_pkg.sv
// constants shared by the serial eeprom instruction and protection block
package eep_pkg;
    // instruction codes, one byte each
    localparam logic [7:0] OP_SET_LATCH = 8'h06;
    localparam logic [7:0] OP_CLR_LATCH = 8'h04;
    localparam logic [7:0] OP_STAT_RD = 8'h05;
    localparam logic [7:0] OP_STAT_WR = 8'h01;
    localparam logic [7:0] OP_ARR_RD = 8'h03;
    localparam logic [7:0] OP_ARR_WR = 8'h02;

    // protection_status bit positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_LATCH_BIT = 1;
    localparam int ST_SIZE_LO_BIT = 2;
    localparam int ST_SIZE_HI_BIT = 3;
    localparam int ST_LOCK_BIT = 7;

    // nonvolatile bits as delivered, volatile bits at power-up
    localparam logic ST_LOCK_RESET = 1'h0;
    localparam logic [1:0] ST_SIZE_RESET = 2'h0;
    localparam logic ST_LATCH_RESET = 1'h0;

    // protect-size encodings
    localparam logic [1:0] PS_NONE = 2'h0;
    localparam logic [1:0] PS_QUARTER = 2'h1;
    localparam logic [1:0] PS_HALF = 2'h2;
    localparam logic [1:0] PS_ALL = 2'h3;

    // serial bit counts
    localparam logic [4:0] BITS_OPCODE = 5'h08;
    localparam logic [4:0] BITS_OP_DATA = 5'h10;
    localparam logic [4:0] BITS_MAX = 5'h1F;
    localparam logic [4:0] BITS_LAST_OP = 5'h07;

    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int STATUS_CYCLE_NS_DEF = 5000000;

    typedef enum logic [0:0] {EEP_SR_IDLE, EEP_SR_CYCLE} eep_sr_state_t;
endpackage : eep_pkg

// ===== eep_sync.sv
// two-flop level synchroniser, one per bit
`timescale 1ns/100ps
module eep_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule : eep_sync

// ===== eep_cycle_timer.sv
// self-timed cycle counter: busy for CYCLES clocks, then a done pulse
`timescale 1ns/100ps
module eep_cycle_timer #(
    parameter int CYCLES = 625000
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic start_in,
    output logic busy_out,
    output logic done_out
);
    localparam int W = $clog2(CYCLES + 1);
    localparam logic [W-1:0] LOAD = W'(CYCLES - 1);

    logic [W-1:0] cnt_reg;

    // start is ignored while a cycle already runs
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cnt_reg <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (busy_out) begin
                if (cnt_reg == '0) begin
                    busy_out <= 1'b0;
                    done_out <= 1'b1;
                end else begin
                    cnt_reg <= cnt_reg - 1'b1;
                end
            end else if (start_in) begin
                busy_out <= 1'b1;
                cnt_reg <= LOAD;
            end
        end
    end
endmodule : eep_cycle_timer

// ===== eep_prot.sv
// serial eeprom instruction decoder, write latch and status protection
`timescale 1ns/100ps
module eep_prot
    import eep_pkg::*;
#(
    parameter int STATUS_CYCLE_NS = STATUS_CYCLE_NS_DEF
) (
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic spi_clk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    input wire logic write_protect_n_in,
    input wire logic mem_write_busy_in,
    input wire logic [1:0] mem_addr_top_in,
    output logic write_latch_out,
    output logic cycle_busy_out,
    output logic [1:0] protect_size_out,
    output logic status_lock_out,
    output logic hard_lock_out,
    output logic mem_write_grant_out,
    output logic mem_addr_protected_out
);
    localparam int STATUS_CYCLES = STATUS_CYCLE_NS / CLK_PERIOD_NS;

    // ---------------- link domain (serial clock) ----------------
    logic frame_fresh_reg;
    logic [4:0] bit_cnt_reg;
    logic [4:0] cur_cnt;
    logic [4:0] cnt_next;
    logic [7:0] shift_in_reg;
    logic [7:0] opcode_reg;
    logic [7:0] opcode_next;
    logic [7:0] status_lnk;
    logic [7:0] stat_sh_reg;
    logic [2:0] rd_idx_reg;
    logic op_known;
    logic frame_ignore;
    logic rd_active;

    // fresh is forced while deselected so the next frame restarts at bit 0
    always_ff @(posedge spi_clk_in or negedge rst_n_in
                or posedge spi_cs_n_in) begin
        if (!rst_n_in) begin
            frame_fresh_reg <= 1'b1;
        end else if (spi_cs_n_in) begin
            frame_fresh_reg <= 1'b1;
        end else begin
            frame_fresh_reg <= 1'b0;
        end
    end

    // opcode classification
    always_comb begin
        cur_cnt = frame_fresh_reg ? 5'h00 : bit_cnt_reg;
        cnt_next = (cur_cnt == BITS_MAX) ? BITS_MAX : cur_cnt + 5'h01;
        opcode_next = {shift_in_reg[6:0], spi_mosi_in};
        op_known = (opcode_reg == OP_SET_LATCH) ||
                   (opcode_reg == OP_CLR_LATCH) ||
                   (opcode_reg == OP_STAT_RD) ||
                   (opcode_reg == OP_STAT_WR) ||
                   (opcode_reg == OP_ARR_RD) ||
                   (opcode_reg == OP_ARR_WR);
        frame_ignore = (cur_cnt >= BITS_OPCODE) && !op_known;
        rd_active = !frame_fresh_reg && (bit_cnt_reg >= BITS_OPCODE) &&
                    (opcode_reg == OP_STAT_RD);
    end

    // count and shift on the rising edge; counts survive deselect so the
    // system side can judge the frame after chip select rises
    always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            bit_cnt_reg <= 5'h00;
            shift_in_reg <= 8'h00;
            opcode_reg <= 8'h00;
        end else if (!frame_ignore) begin
            bit_cnt_reg <= cnt_next;
            if (cur_cnt < BITS_OP_DATA) begin
                shift_in_reg <= opcode_next;
            end
            if (cur_cnt == BITS_LAST_OP) begin
                opcode_reg <= opcode_next;
            end
        end
    end

    // status byte shift register, reloaded every eight bits
    always_ff @(posedge spi_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            stat_sh_reg <= 8'h00;
            rd_idx_reg <= 3'h0;
        end else if (cur_cnt == BITS_LAST_OP) begin
            stat_sh_reg <= status_lnk;
            rd_idx_reg <= 3'h0;
        end else if (rd_active) begin
            rd_idx_reg <= rd_idx_reg + 3'h1;
            if (rd_idx_reg == 3'h7) begin
                stat_sh_reg <= status_lnk;
            end
        end
    end

    // output driven after the falling edge, released on deselect
    always_ff @(negedge spi_clk_in or negedge rst_n_in
                or posedge spi_cs_n_in) begin
        if (!rst_n_in) begin
            spi_miso_out <= 1'b0;
            spi_miso_oe_out <= 1'b0;
        end else if (spi_cs_n_in) begin
            spi_miso_out <= 1'b0;
            spi_miso_oe_out <= 1'b0;
        end else begin
            spi_miso_out <= stat_sh_reg[3'h7 - rd_idx_reg];
            spi_miso_oe_out <= rd_active;
        end
    end

    // ---------------- system domain ----------------
    logic [7:0] status_byte_reg;
    logic [1:0] pin_sync;
    logic cs_sync;
    logic wp_n_sync;
    logic cs_prev_reg;
    logic cs_rise;
    logic mem_busy_prev_reg;
    logic mem_done;
    logic wel_reg;
    logic lock_reg;
    logic [1:0] size_reg;
    logic lock_pend_reg;
    logic [1:0] size_pend_reg;
    logic hard_lock;
    logic busy_now;
    logic do_set;
    logic do_clr;
    logic do_swr;
    logic sr_busy;
    logic sr_done;
    logic addr_hit;
    eep_sr_state_t sr_state_reg;

    // status byte into the serial domain; bits move independently
    eep_sync #(.WIDTH(8)) u_stat_sync (
        .clk_in(spi_clk_in),
        .rst_n_in(rst_n_in),
        .async_in(status_byte_reg),
        .sync_out(status_lnk)
    );

    // chip select and protect pin into the system domain; reset to their
    // idle high levels so no false chip select rise follows reset
    eep_sync #(.WIDTH(2), .RESET_VAL(2'h3)) u_pin_sync (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .async_in({spi_cs_n_in, write_protect_n_in}),
        .sync_out(pin_sync)
    );

    eep_cycle_timer #(.CYCLES(STATUS_CYCLES)) u_sr_timer (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .start_in(do_swr),
        .busy_out(sr_busy),
        .done_out(sr_done)
    );

    // frame verdicts at chip select rise; link counters are quiet then
    always_comb begin
        cs_sync = pin_sync[1];
        wp_n_sync = pin_sync[0];
        cs_rise = cs_sync && !cs_prev_reg;
        mem_done = mem_busy_prev_reg && !mem_write_busy_in;
        hard_lock = lock_reg && !wp_n_sync;
        busy_now = sr_busy || mem_write_busy_in;
        do_set = cs_rise && (bit_cnt_reg == BITS_OPCODE) &&
                 (opcode_reg == OP_SET_LATCH);
        do_clr = cs_rise && (bit_cnt_reg == BITS_OPCODE) &&
                 (opcode_reg == OP_CLR_LATCH);
        // exact bit count demands the rise before the seventeenth edge
        do_swr = cs_rise && (bit_cnt_reg == BITS_OP_DATA) &&
                 (opcode_reg == OP_STAT_WR) &&
                 wel_reg && !busy_now && !hard_lock;
        case (size_reg)
            PS_NONE: addr_hit = 1'b0;
            PS_QUARTER: addr_hit = (mem_addr_top_in == 2'h3);
            PS_HALF: addr_hit = mem_addr_top_in[1];
            default: addr_hit = 1'b1;
        endcase
    end

    // edge history
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_prev_reg <= 1'b1;
            mem_busy_prev_reg <= 1'b0;
        end else begin
            cs_prev_reg <= cs_sync;
            mem_busy_prev_reg <= mem_write_busy_in;
        end
    end

    // write latch; a set arriving with a clear wins
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            wel_reg <= ST_LATCH_RESET;
        end else if (do_set) begin
            wel_reg <= 1'b1;
        end else if (do_clr || sr_done || mem_done) begin
            wel_reg <= 1'b0;
        end
    end

    // status write cycle: new values held aside until completion
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sr_state_reg <= EEP_SR_IDLE;
            lock_reg <= ST_LOCK_RESET;
            size_reg <= ST_SIZE_RESET;
            lock_pend_reg <= ST_LOCK_RESET;
            size_pend_reg <= ST_SIZE_RESET;
        end else begin
            case (sr_state_reg)
                EEP_SR_IDLE: begin
                    if (do_swr) begin
                        lock_pend_reg <= shift_in_reg[ST_LOCK_BIT];
                        size_pend_reg <= {shift_in_reg[ST_SIZE_HI_BIT],
                                          shift_in_reg[ST_SIZE_LO_BIT]};
                        sr_state_reg <= EEP_SR_CYCLE;
                    end
                end
                EEP_SR_CYCLE: begin
                    if (sr_done) begin
                        lock_reg <= lock_pend_reg;
                        size_reg <= size_pend_reg;
                        sr_state_reg <= EEP_SR_IDLE;
                    end
                end
                default: sr_state_reg <= EEP_SR_IDLE;
            endcase
        end
    end

    // readable status byte; unused bits stay zero
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            status_byte_reg <= 8'h00;
        end else begin
            status_byte_reg <= 8'h00;
            status_byte_reg[ST_BUSY_BIT] <= busy_now;
            status_byte_reg[ST_LATCH_BIT] <= wel_reg;
            status_byte_reg[ST_SIZE_LO_BIT] <= size_reg[0];
            status_byte_reg[ST_SIZE_HI_BIT] <= size_reg[1];
            status_byte_reg[ST_LOCK_BIT] <= lock_reg;
        end
    end

    // registered outputs toward the array write path
    always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            write_latch_out <= ST_LATCH_RESET;
            cycle_busy_out <= 1'b0;
            protect_size_out <= ST_SIZE_RESET;
            status_lock_out <= ST_LOCK_RESET;
            hard_lock_out <= 1'b0;
            mem_write_grant_out <= 1'b0;
            mem_addr_protected_out <= 1'b0;
        end else begin
            write_latch_out <= wel_reg;
            cycle_busy_out <= busy_now;
            protect_size_out <= size_reg;
            status_lock_out <= lock_reg;
            hard_lock_out <= hard_lock;
            mem_write_grant_out <= wel_reg && !busy_now;
            mem_addr_protected_out <= addr_hit;
        end
    end
endmodule : eep_prot

// ===== eep_prot_props.sv
// concurrent checks on the protection block ports
`timescale 1ns/100ps
module eep_prot_props
    import eep_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_miso_oe_out,
    input wire logic write_protect_n_in,
    input wire logic mem_write_busy_in,
    input wire logic write_latch_out,
    input wire logic cycle_busy_out,
    input wire logic [1:0] protect_size_out,
    input wire logic status_lock_out,
    input wire logic hard_lock_out,
    input wire logic mem_write_grant_out,
    input wire logic mem_addr_protected_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    // pin path has two sync flops plus a register, so allow slack
    hard_lock_in_a:
    assert property ((status_lock_out && !write_protect_n_in) [*5]
        |-> hard_lock_out) else $error("hard lock missing");
    hard_lock_out_a:
    assert property (write_protect_n_in [*4] |-> !hard_lock_out)
        else $error("hard lock held with pin high");
    lock_needed_a:
    assert property ($rose(hard_lock_out) |-> status_lock_out)
        else $error("hard lock without lock bit");
    grant_latch_a:
    assert property (!write_latch_out && !$past(write_latch_out)
        |-> !mem_write_grant_out) else $error("grant without latch");
    busy_follow_a:
    assert property (mem_write_busy_in |=> cycle_busy_out)
        else $error("busy flag missed array cycle");
    // nonvolatile bits move only at the end of a status cycle; their
    // outputs lag the busy output fall by one clock
    nv_update_a:
    assert property ($changed({status_lock_out, protect_size_out})
        |-> !cycle_busy_out && $past(cycle_busy_out, 2))
        else $error("status bits changed outside cycle end");
    latch_end_a:
    assert property ($fell(cycle_busy_out) |-> ##[0:2] !write_latch_out)
        else $error("latch kept after cycle end");
    oe_idle_a:
    assert property (spi_cs_n_in |-> !spi_miso_oe_out)
        else $error("output driven while deselected");
    size_all_a:
    // size output and address verdict leave the same register stage
    assert property ((protect_size_out == PS_ALL)
        |-> mem_addr_protected_out) else $error("whole array open");
    size_none_a:
    assert property ((protect_size_out == PS_NONE)
        |-> !mem_addr_protected_out) else $error("array guarded");
    cover property ($rose(hard_lock_out));
    cover property ($fell(cycle_busy_out));
    cover property ($rose(spi_miso_oe_out));
endmodule : eep_prot_props

bind eep_prot eep_prot_props props_u (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .spi_cs_n_in(spi_cs_n_in), .spi_miso_oe_out(spi_miso_oe_out),
    .write_protect_n_in(write_protect_n_in),
    .mem_write_busy_in(mem_write_busy_in),
    .write_latch_out(write_latch_out), .cycle_busy_out(cycle_busy_out),
    .protect_size_out(protect_size_out), .status_lock_out(status_lock_out),
    .hard_lock_out(hard_lock_out), .mem_write_grant_out(mem_write_grant_out),
    .mem_addr_protected_out(mem_addr_protected_out)
);

// ===== eep_master_model.sv
// serial bus master model, clock idles at the idle_hi level (low by default) and stands still between frames
`timescale 1ns/100ps
module eep_master_model (
    output logic spi_clk_out,
    output logic spi_cs_n_out,
    output logic spi_mosi_out,
    input wire logic spi_miso_in,
    input wire logic spi_miso_oe_in
);
    localparam int HALF = 40;
    logic idle_hi = 1'b0; // clock level between frames, set by the bench
    initial begin
        spi_clk_out = 1'b0;
        spi_cs_n_out = 1'b1;
        spi_mosi_out = 1'b0;
    end
    // send nb bits msb first, then clock rb bits back in
    task automatic xfer(input logic [15:0] tx, input int nb, input int rb,
                        output logic [7:0] rx);
        rx = 8'h00;
        spi_clk_out = idle_hi; // park at this mode's idle level
        #HALF spi_cs_n_out = 1'b0;
        // idle-high mode falls at the start of a bit, idle-low at the end
        for (int i = nb - 1; i >= 0; i--) begin
            spi_mosi_out = tx[i];
            if (idle_hi) begin
                spi_clk_out = 1'b0;
            end
            #HALF spi_clk_out = 1'b1;
            #HALF;
            if (!idle_hi) begin
                spi_clk_out = 1'b0;
            end
        end
        // idle data line keeps toggling so stale bits never look valid
        for (int i = 0; i < rb; i++) begin
            spi_mosi_out = ~spi_mosi_out;
            if (idle_hi) begin
                spi_clk_out = 1'b0;
            end
            #HALF spi_clk_out = 1'b1;
            rx = {rx[6:0], spi_miso_oe_in ? spi_miso_in : 1'bx};
            #HALF;
            if (!idle_hi) begin
                spi_clk_out = 1'b0;
            end
        end
        #HALF spi_cs_n_out = 1'b1;
        spi_mosi_out = ~spi_mosi_out;
        #(4 * HALF);
    endtask : xfer
endmodule : eep_master_model

// ===== eep_prot_test.sv
// self-checking bench for the protection block with a serial master model
`timescale 1ns/100ps
module eep_prot_test;
    import eep_pkg::*;
    localparam int CYC_NS = 8000; // 1000 clocks, long enough to poll
    logic sys_clk_in = 1'b0;
    logic rst_n_in, write_protect_n_in, mem_write_busy_in;
    logic [1:0] mem_addr_top_in;
    logic spi_clk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe;
    logic write_latch, cycle_busy, status_lock, hard_lock, grant, addr_prot;
    logic [1:0] protect_size;
    logic [7:0] bad_ops [3] = '{8'hFF, OP_ARR_RD, OP_ARR_WR};
    int err_count = 0;
    int check_count = 0;
    int cycle_count = 0;

    always #4 sys_clk_in = ~sys_clk_in;

    eep_prot #(.STATUS_CYCLE_NS(CYC_NS)) dut_u (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .spi_clk_in(spi_clk), .spi_cs_n_in(spi_cs_n),
        .spi_mosi_in(spi_mosi), .spi_miso_out(spi_miso),
        .spi_miso_oe_out(spi_miso_oe),
        .write_protect_n_in(write_protect_n_in),
        .mem_write_busy_in(mem_write_busy_in),
        .mem_addr_top_in(mem_addr_top_in), .write_latch_out(write_latch),
        .cycle_busy_out(cycle_busy), .protect_size_out(protect_size),
        .status_lock_out(status_lock), .hard_lock_out(hard_lock),
        .mem_write_grant_out(grant), .mem_addr_protected_out(addr_prot)
    );
    eep_master_model mdl_u (
        .spi_clk_out(spi_clk), .spi_cs_n_out(spi_cs_n),
        .spi_mosi_out(spi_mosi), .spi_miso_in(spi_miso),
        .spi_miso_oe_in(spi_miso_oe)
    );

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t ns seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_sys(input int n);
        repeat (n) @(negedge sys_clk_in);
    endtask : wait_sys

    // one frame, then time for the verdict to cross into the sys domain
    task automatic cmd(input logic [15:0] tx, input int nb);
        logic [7:0] d;
        mdl_u.xfer(tx, nb, 0, d);
        wait_sys(10);
    endtask : cmd

    // two status bytes clocked out, the repeat is compared
    task automatic rd_st(input logic [7:0] exp);
        logic [7:0] d;
        mdl_u.xfer(16'h0005, 8, 16, d);
        check(d, exp);
        wait_sys(10);
    endtask : rd_st

    task automatic st_wr(input logic [7:0] d);
        cmd(16'(OP_SET_LATCH), 8);
        cmd({OP_STAT_WR, d}, 16);
        wait_sys(1100);
    endtask : st_wr

    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : close_out

    // hang guard well above the expected run length
    always @(posedge sys_clk_in) begin
        cycle_count++;
        if (cycle_count == 40000) begin
            err_count++;
            close_out();
        end
    end

    initial begin
        rst_n_in = 1'b0;
        write_protect_n_in = 1'b1;
        mem_write_busy_in = 1'b0;
        mem_addr_top_in = 2'h0;
        repeat (10) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        wait_sys(5);
        rd_st(8'h00);
        cmd(16'(OP_SET_LATCH), 8);
        check(write_latch, 1'b1);
        mdl_u.idle_hi = 1'b1; // clock idles high for two frames
        rd_st(8'h02);
        cmd(16'(OP_CLR_LATCH), 8);
        check(write_latch, 1'b0);
        mdl_u.idle_hi = 1'b0;
        cmd({OP_STAT_WR, 8'hFF}, 16);
        wait_sys(1100);
        check(status_lock, 1'b0);
        cmd(16'(OP_SET_LATCH), 8);
        cmd({1'b0, OP_STAT_WR, 7'h7F}, 15);
        wait_sys(1100);
        check(status_lock, 1'b0);
        cmd({OP_STAT_WR, 8'hFF}, 16);
        check(cycle_busy, 1'b1);
        rd_st(8'h03);
        wait_sys(1100);
        rd_st(8'h8C);
        check(protect_size, PS_ALL);
        write_protect_n_in = 1'b0;
        wait_sys(10);
        check(hard_lock, 1'b1);
        st_wr(8'h00);
        rd_st(8'h8E);
        write_protect_n_in = 1'b1;
        wait_sys(10);
        check(hard_lock, 1'b0);
        st_wr(8'h00);
        rd_st(8'h00);
        write_protect_n_in = 1'b0;
        st_wr(8'h84);
        rd_st(8'h84);
        check(hard_lock, 1'b1);
        write_protect_n_in = 1'b1;
        // every size code against every address quarter
        for (int s = 0; s < 4; s++) begin
            wait_sys(10);
            st_wr(8'(s << 2));
            for (int a = 0; a < 4; a++) begin
                mem_addr_top_in = 2'(a);
                wait_sys(3);
                // quarter guards top 11, half guards top 1x
                check(addr_prot, s == 3 || (s == 2 && a > 1) ||
                      (s == 1 && a == 3));
            end
        end
        foreach (bad_ops[i]) begin
            cmd({bad_ops[i], OP_SET_LATCH}, 16);
            check(write_latch, 1'b0);
        end
        cmd(16'(OP_SET_LATCH), 8);
        check(grant, 1'b1);
        mem_write_busy_in = 1'b1;
        wait_sys(3);
        check(cycle_busy, 1'b1);
        mem_write_busy_in = 1'b0;
        wait_sys(3);
        check(write_latch, 1'b0);
        check(cycle_busy, 1'b0);
        close_out();
    end
endmodule : eep_prot_test
